// [hdl/sas_defines.svh]
// Constants of the converter sequencer: reset values and timing counts
`ifndef SAS_DEFINES_SVH
`define SAS_DEFINES_SVH

// Converter clock cycles, counted in half cycles
`define SAS_HALF_NORMAL 8'd26
`define SAS_HALF_FIRST 8'd50
`define SAS_HALF_AUTO 8'd27
`define SAS_SH_NORMAL 8'd3
`define SAS_SH_FIRST 8'd27
`define SAS_SH_AUTO 8'd4
// Trigger synchroniser length in CPU cycles
`define SAS_SYNC_CYCLES 2'd3
// Source index meaning free running
`define SAS_SRC_FREE 3'h0
`define SAS_RST_DIV 3'h0
`define SAS_RST_RESULT 10'h000

`endif

// [hdl/sas_pkg.sv]
// Types of the converter sequencer
package sas_pkg;
  typedef enum logic [1:0] {
    SAS_IDLE,
    SAS_WAIT,
    SAS_CONV
  } sas_state_e;
  typedef enum logic [1:0] {
    SAS_KIND_NORMAL,
    SAS_KIND_FIRST,
    SAS_KIND_AUTO
  } sas_kind_e;
endpackage

// [hdl/sas_fifo.sv]
// Result FIFO with valid/ready on both sides
`timescale 1ns/10ps
module sas_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  assign o_in_ready = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// [hdl/sas_sequencer.sv]
// Successive approximation converter sequencer: prescaler, starts, timing, result lock
`timescale 1ns/10ps
`include "sas_defines.svh"
module sas_sequencer #(
  parameter int RES_W = 10,
  parameter int FIFO_DEPTH = 16,
  parameter int NSRC = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // Control bits
  input wire logic i_conv_power_reduce,
  input wire logic i_conv_enable,
  input wire logic i_conv_start_set,
  input wire logic i_auto_trigger_enable,
  input wire logic [2:0] i_trigger_source_select,
  input wire logic [NSRC-1:0] i_trig_sources,
  input wire logic [2:0] i_clock_divider_select,
  input wire logic i_result_left_align,
  input wire logic [1:0] i_reference_select,
  input wire logic [3:0] i_channel_select,
  input wire logic i_irq_enable,
  input wire logic i_flag_clear,
  input wire logic i_irq_ack,
  input wire logic i_read_low,
  input wire logic i_read_high,
  // Analog core
  input wire logic i_cmp_result_valid,
  input wire logic [RES_W-1:0] i_cmp_result,
  output logic o_conv_running,
  output logic o_sample_hold,
  output logic o_conv_clk,
  output logic [1:0] o_reference_select,
  output logic [3:0] o_channel_select,
  // Status
  output logic o_conv_start,
  output logic o_conv_complete_flag,
  output logic o_irq,
  output logic [7:0] o_result_high_byte,
  output logic [7:0] o_result_low_byte,
  output logic o_result_dropped,
  // Result stream
  output logic o_res_valid,
  input wire logic i_res_ready,
  output logic [RES_W-1:0] o_res_data
);
  logic [6:0] pre_q;
  logic [6:0] pre_d;
  logic conv_clk_q;
  sas_pkg::sas_state_e st_q;
  sas_pkg::sas_kind_e kind_q;
  logic [7:0] half_q;
  logic first_q;
  logic start_q;
  logic flag_q;
  logic lock_q;
  logic drop_q;
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic [1:0] ref_q;
  logic [3:0] ch_q;
  logic sh_q;
  logic irq_q;
  logic [2:0] trig_sync_q;
  logic trig_prev_q;
  logic flag_prev_q;
  logic [RES_W-1:0] res_q;
  logic res_push_q;
  logic fifo_in_ready;

  // ==========================================
  // Prescaler
  wire active = i_conv_enable && !i_conv_power_reduce;
  // Ratio 2^sel, with select 0 and 1 both dividing by two
  wire [2:0] div_shift = 3'h7 - i_clock_divider_select;
  wire [6:0] div_mask =
      (i_clock_divider_select <= 3'h1) ? 7'h01 : 7'(7'h7F >> div_shift);
  wire [6:0] half_mask = 7'(div_mask >> 1);
  // Trigger edge source, synchronised over three CPU cycles
  wire sel_trig = i_trig_sources[i_trigger_source_select];
  wire trig_s = trig_sync_q[2];
  wire trig_rise = trig_s && !trig_prev_q;
  wire free_mode = i_auto_trigger_enable && (i_trigger_source_select == `SAS_SRC_FREE);
  wire auto_rise = i_auto_trigger_enable && !free_mode && trig_rise;
  wire pre_wrap = (pre_q & div_mask) == div_mask;
  // Half converter cycle tick: prescaler midpoint or wrap
  wire tick_rise = pre_wrap;
  wire tick_half = (pre_q & div_mask) == half_mask;
  wire tick = tick_rise || tick_half;
  wire [7:0] total_half = (kind_q == sas_pkg::SAS_KIND_FIRST) ? `SAS_HALF_FIRST :
      (kind_q == sas_pkg::SAS_KIND_AUTO) ? `SAS_HALF_AUTO : `SAS_HALF_NORMAL;
  wire [7:0] sh_half = (kind_q == sas_pkg::SAS_KIND_FIRST) ? `SAS_SH_FIRST :
      (kind_q == sas_pkg::SAS_KIND_AUTO) ? `SAS_SH_AUTO : `SAS_SH_NORMAL;
  wire done = (st_q == sas_pkg::SAS_CONV) && tick && (half_q == total_half - 8'd1);
  wire last_cycle = (st_q == sas_pkg::SAS_CONV) && (half_q >= total_half - 8'd2);
  wire chain = done && (free_mode || start_q && i_conv_start_set);
  wire [RES_W-1:0] res_val = i_cmp_result_valid ? i_cmp_result : res_q;
  wire [15:0] aligned = i_result_left_align ? {res_val, 6'h00} : {6'h00, res_val};

  // prescaler divide, held reset when off
  assign pre_d = (!active || (st_q == sas_pkg::SAS_IDLE && auto_rise)) ? 7'h00 : pre_q + 7'h01;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pre_q <= 7'h00;
      conv_clk_q <= 1'b0;
      trig_sync_q <= 3'h0;
      trig_prev_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      conv_clk_q <= active && ((pre_d & div_mask) <= half_mask);
      trig_sync_q <= {trig_sync_q[1:0], sel_trig};
      trig_prev_q <= trig_s;
    end
  end

  // ==========================================
  // Conversion state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= sas_pkg::SAS_IDLE;
      kind_q <= sas_pkg::SAS_KIND_NORMAL;
      half_q <= 8'h00;
      first_q <= 1'b1;
      start_q <= 1'b0;
      sh_q <= 1'b0;
    end else if (!active) begin
      st_q <= sas_pkg::SAS_IDLE;
      half_q <= 8'h00;
      first_q <= 1'b1;
      start_q <= 1'b0;
      sh_q <= 1'b0;
    end else begin
      sh_q <= (st_q == sas_pkg::SAS_CONV) && tick && (half_q == sh_half - 8'd1);
      case (st_q)
        sas_pkg::SAS_IDLE: begin
          if (i_conv_start_set) begin
            start_q <= 1'b1;
            st_q <= sas_pkg::SAS_WAIT;
          end else if (auto_rise) begin
            start_q <= 1'b1;
            half_q <= 8'h00;
            kind_q <= first_q ? sas_pkg::SAS_KIND_FIRST : sas_pkg::SAS_KIND_AUTO;
            st_q <= sas_pkg::SAS_CONV;
          end
        end
        sas_pkg::SAS_WAIT: begin
          // begin on next converter clock rising edge
          if (tick_rise) begin
            half_q <= 8'h00;
            kind_q <= first_q ? sas_pkg::SAS_KIND_FIRST : sas_pkg::SAS_KIND_NORMAL;
            st_q <= sas_pkg::SAS_CONV;
          end
        end
        sas_pkg::SAS_CONV: begin
          if (tick) begin
            half_q <= half_q + 8'd1;
          end
          if (done) begin
            first_q <= 1'b0;
            half_q <= 8'h00;
            if (chain) begin
              // free running or a start bit still set restarts at once, start stays set
              kind_q <= sas_pkg::SAS_KIND_NORMAL;
            end else begin
              start_q <= 1'b0;
              st_q <= sas_pkg::SAS_IDLE;
            end
          end
        end
        default: begin
          st_q <= sas_pkg::SAS_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Selections, result bytes, flag
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ref_q <= 2'h0;
      ch_q <= 4'h0;
      flag_q <= 1'b0;
      lock_q <= 1'b0;
      drop_q <= 1'b0;
      hi_q <= 8'h00;
      lo_q <= 8'h00;
      irq_q <= 1'b0;
      res_q <= `SAS_RST_RESULT;
      res_push_q <= 1'b0;
      flag_prev_q <= 1'b0;
    end else begin
      if (active && (st_q != sas_pkg::SAS_CONV || last_cycle)) begin
        ref_q <= i_reference_select;
        ch_q <= i_channel_select;
      end
      if (i_cmp_result_valid) begin
        res_q <= i_cmp_result;
      end
      // low byte read locks, high byte read unlocks
      if (i_read_high) begin
        lock_q <= 1'b0;
      end else if (i_read_low) begin
        lock_q <= 1'b1;
      end
      if (done && !lock_q) begin
        hi_q <= aligned[15:8];
        lo_q <= aligned[7:0];
      end
      drop_q <= done && lock_q;
      res_push_q <= done;
      // flag sets regardless of lock or mask; set beats clear
      if (done) begin
        flag_q <= 1'b1;
      end else if (i_flag_clear || i_irq_ack) begin
        flag_q <= 1'b0;
      end
      flag_prev_q <= flag_q;
      irq_q <= flag_q && i_irq_enable && !i_irq_ack;
    end
  end

  sas_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(res_push_q),
    .o_in_ready(fifo_in_ready),
    .i_in_data(res_q),
    .o_out_valid(o_res_valid),
    .i_out_ready(i_res_ready),
    .o_out_data(o_res_data)
  );

  assign o_conv_running = (st_q == sas_pkg::SAS_CONV);
  assign o_sample_hold = sh_q;
  assign o_conv_clk = conv_clk_q;
  assign o_reference_select = ref_q;
  assign o_channel_select = ch_q;
  assign o_conv_start = start_q;
  assign o_conv_complete_flag = flag_q;
  assign o_irq = irq_q;
  assign o_result_high_byte = hi_q;
  assign o_result_low_byte = lo_q;
  assign o_result_dropped = drop_q;
endmodule

// [dv/sas_seq_asserts.sv]
// Port checker of the converter sequencer
`timescale 1ns/10ps
module sas_seq_asserts (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_conv_enable,
  input wire logic i_read_low,
  input wire logic i_read_high,
  input wire logic i_flag_clear,
  input wire logic i_irq_ack,
  input wire logic i_irq_enable,
  input wire logic o_conv_running,
  input wire logic o_sample_hold,
  input wire logic o_conv_start,
  input wire logic o_conv_complete_flag,
  input wire logic o_irq,
  input wire logic [7:0] o_result_high_byte,
  input wire logic [7:0] o_result_low_byte,
  input wire logic o_result_dropped
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  logic lock_q;
  // ==========
  // Result lock tracker
  always_ff @(posedge i_clk) begin
    if (i_rst || i_read_high) begin
      lock_q <= 1'b0;
    end else if (i_read_low) begin
      lock_q <= 1'b1;
    end
  end
  // ==========
  // Properties
  property p_busy; o_conv_running |-> o_conv_start; endproperty
  a_busy: assert property (p_busy) else $error("start bit low");
  property p_off; !i_conv_enable && !$past(i_conv_enable) |-> !o_conv_running; endproperty
  a_off: assert property (p_off) else $error("runs disabled");
  property p_sh; $rose(o_conv_running) |-> ##[1:900] o_sample_hold; endproperty
  a_sh: assert property (p_sh) else $error("no strobe");
  property p_clr; o_conv_complete_flag && (i_flag_clear || i_irq_ack) && !o_conv_running
    && !$past(o_conv_running) |=> !o_conv_complete_flag; endproperty
  a_clr: assert property (p_clr) else $error("flag kept");
  property p_irq; (o_conv_complete_flag && i_irq_enable) [*2] |-> o_irq; endproperty
  a_irq: assert property (p_irq) else $error("irq low");
  property p_noirq; (!o_conv_complete_flag || !i_irq_enable) [*2] |-> !o_irq; endproperty
  a_noirq: assert property (p_noirq) else $error("irq high");
  property p_dflag; o_result_dropped |-> ##[0:1] o_conv_complete_flag; endproperty
  a_dflag: assert property (p_dflag) else $error("drop no flag");
  property p_lock; lock_q && !i_read_high |=> $stable({o_result_high_byte, o_result_low_byte});
  endproperty
  a_lock: assert property (p_lock) else $error("locked bytes moved");
  property p_dlock; o_result_dropped |-> $past(lock_q); endproperty
  a_dlock: assert property (p_dlock) else $error("drop unlocked");
  c_drop: cover property (o_result_dropped);
  c_irq: cover property (o_irq);
  c_sh: cover property (o_sample_hold);
endmodule
bind sas_sequencer sas_seq_asserts u_chk (.*);

// [dv/sas_analog_model.sv]
// Behavioural sample-hold and approximation core
`timescale 1ns/10ps
module sas_analog_model (
  input wire logic i_clk,
  input wire logic i_sample_hold,
  input wire logic [3:0] i_channel_select,
  input wire logic i_slow,
  output logic o_valid,
  output logic [9:0] o_result
);
  logic [9:0] held_q = 10'h000;
  int wait_q = 0;
  initial o_valid = 1'b0;
  initial o_result = 10'h2AA;
  always @(posedge i_clk) begin
    wait_q <= i_sample_hold ? (i_slow ? 12 : 2) : (wait_q > 0 ? wait_q - 1 : 0);
    if (i_sample_hold) begin
      held_q <= {i_channel_select, 6'h15};
    end
    o_valid <= (wait_q == 1);
    // Data toggles while not valid
    o_result <= (wait_q == 1) ? held_q : ~o_result;
  end
endmodule

// [dv/sas_sequencer_test.sv]
// Self-checking bench of the converter sequencer
`timescale 1ns/10ps
module sas_sequencer_test;
  logic clk, rst, pr, en, st, ate, la, ie, fc, ack, rl, rh, cv, rdy, slow;
  logic run, sh, cclk, fl, irq, cs, drp, rv;
  logic [2:0] src, div;
  logic [7:0] trig, hb, lb;
  logic [1:0] rs, ro;
  logic [3:0] ch, co;
  logic [9:0] cr, rd;
  int miscompares = 0;
  int total_checks = 0;
  int drops = 0;
  int n;
  sas_sequencer dut (.i_clk(clk), .i_rst(rst), .i_conv_power_reduce(pr), .i_conv_enable(en),
    .i_conv_start_set(st), .i_auto_trigger_enable(ate), .i_trigger_source_select(src),
    .i_trig_sources(trig), .i_clock_divider_select(div), .i_result_left_align(la),
    .i_reference_select(rs), .i_channel_select(ch), .i_irq_enable(ie), .i_flag_clear(fc),
    .i_irq_ack(ack), .i_read_low(rl), .i_read_high(rh), .i_cmp_result_valid(cv),
    .i_cmp_result(cr), .o_conv_running(run), .o_sample_hold(sh), .o_conv_clk(cclk),
    .o_reference_select(ro), .o_channel_select(co), .o_conv_start(cs),
    .o_conv_complete_flag(fl), .o_irq(irq), .o_result_high_byte(hb),
    .o_result_low_byte(lb), .o_result_dropped(drp), .o_res_valid(rv),
    .i_res_ready(rdy), .o_res_data(rd));
  sas_analog_model model (.i_clk(clk), .i_sample_hold(sh), .i_channel_select(co),
    .i_slow(slow), .o_valid(cv), .o_result(cr));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (drp === 1'b1) drops++;
  end
  // ==========
  // Helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
  endtask
  task automatic wait_flag(output int k);
    k = 0;
    while (fl !== 1'b1 && k < 2000) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic end_sim;
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_off;
    pulse(st);
    cyc(40);
    check("running", run, 0);
    check("ref out", ro, 0);
    check("conv clk", cclk, 0);
  endtask
  task automatic t_single;
    pr = 0;
    en = 1;
    cyc(2);
    check("ref out", ro, 1);
    pulse(st);
    check("start", cs, 1);
    cyc(4);
    ch = 4'h3;
    wait_flag(n);
    check("first len", n >= 44 && n <= 50, 1);
    check("start", cs, 0);
    check("high", hb, 8'h01);
    check("low", lb, 8'h55);
    pulse(fc);
    la = 1;
    slow = 1;
    pulse(st);
    wait_flag(n);
    check("len", n >= 26 && n <= 31, 1);
    check("high", hb, 8'h35);
    check("low", lb, 8'h40);
  endtask
  task automatic t_div;
    logic prev;
    div = 3'h3;
    cyc(8);
    prev = cclk;
    n = 0;
    repeat (64) begin
      cyc(1);
      if (cclk === 1'b1 && prev === 1'b0) n++;
      prev = cclk;
    end
    check("rises", n, 8);
    div = 3'h0;
    cyc(8);
  endtask
  task automatic t_lock;
    pulse(fc);
    pulse(rl);
    ch = 4'h7;
    pulse(st);
    wait_flag(n);
    check("locked", hb, 8'h35);
    cyc(1);
    check("drops", drops, 1);
    pulse(rh);
    pulse(fc);
    pulse(st);
    wait_flag(n);
    check("unlocked", hb, 8'h75);
  endtask
  task automatic t_irq;
    check("masked", irq, 0);
    ie = 1;
    cyc(2);
    check("irq", irq, 1);
    pulse(ack);
    cyc(1);
    check("flag", fl, 0);
    check("irq", irq, 0);
    ie = 0;
  endtask
  task automatic t_auto;
    ate = 1;
    src = 3'h2;
    cyc(2);
    trig[2] = 1;
    cyc(10);
    trig[2] = 0;
    cyc(2);
    trig[2] = 1;
    wait_flag(n);
    check("auto len", n >= 16 && n <= 24, 1);
    cyc(40);
    check("retrig", run, 0);
    pulse(fc);
    pulse(st);
    wait_flag(n);
    check("sw len", n >= 26 && n <= 31, 1);
    trig[2] = 0;
  endtask
  task automatic t_free;
    pulse(fc);
    src = 3'h0;
    rdy = 0;
    pulse(st);
    wait_flag(n);
    check("start", cs, 1);
    pulse(fc);
    cyc(3);
    check("chained", run, 1);
    cyc(560);
    ate = 0;
    en = 0;
    cyc(5);
    rdy = 1;
    n = 0;
    repeat (40) begin
      if (rv === 1'b1 && n == 0) check("word", rd, 10'h1D5);
      if (rv === 1'b1) n++;
      cyc(1);
    end
    check("words", n, 16);
  endtask
  initial begin
    {en, st, ate, la, ie, fc, ack, rl, rh, slow} = '0;
    {rst, pr, rdy} = 3'h7;
    src = 3'h0;
    div = 3'h0;
    trig = 8'h00;
    rs = 2'h1;
    ch = 4'h5;
    cyc(20);
    rst = 0;
    t_off();
    t_single();
    t_div();
    t_lock();
    t_irq();
    t_auto();
    t_free();
    end_sim();
  end
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule
